// [hw/ctw_params.svh]
// Holds the named constants of the core timer chain.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef CTW_PARAMS_SVH
`define CTW_PARAMS_SVH

// ***********************************************************************
// Register addresses
// ***********************************************************************
`define CTW_ADDR_W        14
`define CTW_OFS_STATUS    14'h0008
`define CTW_OFS_COUNT     14'h0009
`define CTW_OFS_WDOG      14'h3FF0

// ***********************************************************************
// Status and control fields
// ***********************************************************************
`define CTW_BIT_OVF_FLAG   7
`define CTW_BIT_PER_FLAG   6
`define CTW_BIT_OVF_IE     5
`define CTW_BIT_PER_IE     4
`define CTW_BIT_OVF_CLR    3
`define CTW_BIT_PER_CLR    2
`define CTW_BIT_RATE_HI    1
`define CTW_BIT_RATE_LO    0
`define CTW_BIT_WDOG_CLR   0
`define CTW_RATE_RESET     2'h3
`define CTW_COUNT_RESET    8'h00
`define CTW_RDATA_RESET    8'h00

// ***********************************************************************
// Chain layout and timing
// ***********************************************************************
`define CTW_CHAIN_W       17
`define CTW_CHAIN_ZERO    17'h00000
`define CTW_CHAIN_ONE     17'h00001
`define CTW_PRE_MASK      17'h00003
`define CTW_OVF_MASK      17'h003FF
`define CTW_CNT_LSB       2
`define CTW_CNT_MSB       9
`define CTW_PER_MASK0     17'h03FFF
`define CTW_PER_MASK1     17'h07FFF
`define CTW_PER_MASK2     17'h0FFFF
`define CTW_PER_MASK3     17'h1FFFF
`define CTW_POR_CYCLES    4064
`define CTW_POR_W         12
`define CTW_WDOG_W        3
`define CTW_WDOG_LAST     3'h7
`define CTW_WDOG_ZERO     3'h0
`define CTW_WDOG_ONE      3'h1

`endif

// [hw/ctw_pkg.sv]
// Holds the types shared by the core timer modules.
// Assumes nothing beyond a SystemVerilog compiler.
package ctw_pkg;

  // Power-on sequencer states, Gray along the path
  typedef enum logic [1:0] {
    CTW_POR_COUNT = 2'h0,
    CTW_POR_RUN   = 2'h1
  } ctw_por_state_t;

endpackage

// [hw/ctw_link_if.sv]
// Carries signals between the timer top and its helper modules.
// Assumes all parties run on the one system clock.
`timescale 1ns/10ps
`default_nettype none

interface ctw_link_if;
  logic porActive;
  logic porDone;
  logic periodicTick;
  logic wdogClear;
  logic wdogExpire;
  logic chainClear;

  modport top (
    input  porActive, porDone, wdogExpire,
    output periodicTick, wdogClear, chainClear
  );
  modport por (
    output porActive, porDone
  );
  modport wdog (
    input  periodicTick, wdogClear, chainClear,
    output wdogExpire
  );
endinterface

`default_nettype wire

// [hw/ctw_por_seq.sv]
// Holds the power-on sequencer that counts the release delay.
// Assumes reset_n is the power-on reset of the device.
`timescale 1ns/10ps
`default_nettype none
`include "ctw_params.svh"

module ctw_por_seq #(
  parameter int PorCycles = `CTW_POR_CYCLES
) (
  // Clock and reset
  input wire logic  clk,
  input wire logic  reset_n,
  // Link to top
  ctw_link_if.por   link
);

  localparam logic [`CTW_POR_W-1:0] PorLast = `CTW_POR_W'(PorCycles - 1);

  ctw_pkg::ctw_por_state_t state;
  logic [`CTW_POR_W-1:0]   porCount;

  // ***********************************************************************
  // Delay count
  // ***********************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state         <= ctw_pkg::CTW_POR_COUNT;
      porCount      <= '0;
      link.porDone  <= 1'b0;
    end else begin
      link.porDone <= 1'b0;
      case (state)
        ctw_pkg::CTW_POR_COUNT: begin
          if (porCount == PorLast) begin
            state        <= ctw_pkg::CTW_POR_RUN;
            link.porDone <= 1'b1;
          end else begin
            porCount <= porCount + 1'b1;
          end
        end
        ctw_pkg::CTW_POR_RUN: begin
          state <= ctw_pkg::CTW_POR_RUN;
        end
        default: begin
          state <= ctw_pkg::CTW_POR_COUNT;
        end
      endcase
    end
  end

  assign link.porActive = (state != ctw_pkg::CTW_POR_RUN);

  property p_por_len;
    @(posedge clk) disable iff (!reset_n)
    $rose(link.porDone) |-> porCount == PorLast;
  endproperty
  a_por_len: assert property (p_por_len)
    else $error("power-on release at wrong count");

endmodule

`default_nettype wire

// [hw/ctw_wdog.sv]
// Holds the divide-by-eight watchdog stage after the periodic tap.
// Assumes periodicTick is a one-cycle pulse per selected period.
`timescale 1ns/10ps
`default_nettype none
`include "ctw_params.svh"

module ctw_wdog #(
  parameter bit WdogEnable = 1'b1
) (
  // Clock and reset
  input wire logic  clk,
  input wire logic  reset_n,
  // Link to top
  ctw_link_if.wdog  link
);

  logic [`CTW_WDOG_W-1:0] stage;

  // ***********************************************************************
  // Final divider
  // ***********************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage           <= `CTW_WDOG_ZERO;
      link.wdogExpire <= 1'b0;
    end else begin
      link.wdogExpire <= 1'b0;
      if (link.chainClear || link.wdogClear) begin
        stage <= `CTW_WDOG_ZERO;
      end else if (link.periodicTick) begin
        stage <= stage + `CTW_WDOG_ONE;
        if (stage == `CTW_WDOG_LAST) begin
          link.wdogExpire <= WdogEnable;
        end
      end
    end
  end

  property p_clear;
    @(posedge clk) disable iff (!reset_n)
    link.wdogClear |=> stage == `CTW_WDOG_ZERO && !link.wdogExpire;
  endproperty
  a_clear: assert property (p_clear)
    else $error("watchdog clear did not reset final stage");

  property p_expire;
    @(posedge clk) disable iff (!reset_n)
    link.wdogExpire |-> $past(stage) == `CTW_WDOG_LAST &&
                        $past(link.periodicTick);
  endproperty
  a_expire: assert property (p_expire)
    else $error("watchdog expired early");

endmodule

`default_nettype wire

// [hw/ctw_core_timer.sv]
// Holds the core timer top: chain, flags, registers, watchdog and reset.
// Assumes a CPU bus with one-cycle read and write strobes, synchronous.
`timescale 1ns/10ps
`default_nettype none
`include "ctw_params.svh"

// How it works
// - Divide-by-four prescaler clocks 8-bit counter
// - Counter overflow every 1024 clocks
// - Overflow flag sets on FF to 00
// - Overflow flag with enable requests interrupt
// - Periodic taps at 2^14..2^17 via selector
// - Periodic flag sets on selected tap
// - Periodic flag with enable requests interrupt
// - Reset clears both flags and enables
// - Overflow clear bit reads zero, one clears
// - Periodic clear bit reads zero, one clears
// - Rate select picks 2^14 to 2^17
// - Reset sets both rate select bits
// - Watchdog counts periodic output by eight
// - Watchdog expiry raises internal reset
// - Clear resets only final eight-stage
// - Count register at 09 reads counter
// - Power-on counts 4064 then clears chain
// - External reset clears whole chain
// - Chain runs in wait, irq wakes
// - Status and control register at 08
module ctw_core_timer #(
  parameter bit WdogEnable = 1'b1,
  parameter int PorCycles  = `CTW_POR_CYCLES
) (
  // Clock and power-on reset
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // External reset pin and wait mode
  input  wire logic                   extReset_n,
  input  wire logic                   waitMode,
  // CPU register port
  input  wire logic [`CTW_ADDR_W-1:0] addr,
  input  wire logic                   wrEn,
  input  wire logic                   rdEn,
  input  wire logic [7:0]             wrData,
  output var  logic [7:0]             rdData,
  // Interrupt, wake and reset requests
  output var  logic                   irqReq,
  output var  logic                   wakeReq,
  output var  logic                   cpuResetReq,
  output var  logic                   porBusy
);

  ctw_link_if link ();

  logic [`CTW_CHAIN_W-1:0] chainCount;
  logic [7:0]              countValue;
  logic                    overflowFlag;
  logic                    periodicFlag;
  logic                    overflowIrqEnable;
  logic                    periodicIrqEnable;
  logic [1:0]              rateSelect;
  logic [`CTW_CHAIN_W-1:0] perMask;
  logic                    ovfEvent;
  logic                    preTick;
  logic                    intReset;
  logic                    wrStatus;
  logic                    rdStatus;
  logic                    rdCount;
  logic [7:0]              statusValue;
  logic                    next_irqReq;

  // ***********************************************************************
  // Helper modules
  // ***********************************************************************
  ctw_por_seq #(
    .PorCycles (PorCycles)
  ) u_por (
    .clk     (clk),
    .reset_n (reset_n),
    .link    (link.por)
  );

  ctw_wdog #(
    .WdogEnable (WdogEnable)
  ) u_wdog (
    .clk     (clk),
    .reset_n (reset_n),
    .link    (link.wdog)
  );

  // ***********************************************************************
  // Decode and internal reset
  // ***********************************************************************
  assign wrStatus = wrEn && addr == `CTW_OFS_STATUS;
  assign rdStatus = rdEn && addr == `CTW_OFS_STATUS;
  assign rdCount  = rdEn && addr == `CTW_OFS_COUNT;

  assign link.wdogClear = wrEn && addr == `CTW_OFS_WDOG &&
                          !wrData[`CTW_BIT_WDOG_CLR];
  assign intReset = !extReset_n || link.porActive || link.wdogExpire;
  assign link.chainClear = !extReset_n || link.porDone ||
                           link.wdogExpire;

  // ***********************************************************************
  // Timer chain
  // ***********************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chainCount <= `CTW_CHAIN_ZERO;
    end else if (link.chainClear) begin
      chainCount <= `CTW_CHAIN_ZERO;
    end else begin
      chainCount <= chainCount + `CTW_CHAIN_ONE;
    end
  end

  assign countValue = chainCount[`CTW_CNT_MSB:`CTW_CNT_LSB];
  assign preTick    = (chainCount & `CTW_PRE_MASK) == `CTW_PRE_MASK;
  assign ovfEvent   = (chainCount & `CTW_OVF_MASK) == `CTW_OVF_MASK &&
                      !link.chainClear;

  always_comb begin
    case (rateSelect)
      2'h0:    perMask = `CTW_PER_MASK0;
      2'h1:    perMask = `CTW_PER_MASK1;
      2'h2:    perMask = `CTW_PER_MASK2;
      2'h3:    perMask = `CTW_PER_MASK3;
      default: perMask = `CTW_PER_MASK3;
    endcase
  end

  assign link.periodicTick = (chainCount & perMask) == perMask &&
                             !link.chainClear;

  // ***********************************************************************
  // Status and control register
  // ***********************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      overflowIrqEnable <= 1'b0;
      periodicIrqEnable <= 1'b0;
      rateSelect        <= `CTW_RATE_RESET;
    end else if (intReset) begin
      overflowIrqEnable <= 1'b0;
      periodicIrqEnable <= 1'b0;
      rateSelect        <= `CTW_RATE_RESET;
    end else if (wrStatus) begin
      overflowIrqEnable <= wrData[`CTW_BIT_OVF_IE];
      periodicIrqEnable <= wrData[`CTW_BIT_PER_IE];
      rateSelect <= {wrData[`CTW_BIT_RATE_HI], wrData[`CTW_BIT_RATE_LO]};
    end
  end

  // Flags: a set in the same cycle as a clear wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      overflowFlag <= 1'b0;
    end else if (intReset) begin
      overflowFlag <= 1'b0;
    end else if (ovfEvent) begin
      overflowFlag <= 1'b1;
    end else if (wrStatus && wrData[`CTW_BIT_OVF_CLR]) begin
      overflowFlag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      periodicFlag <= 1'b0;
    end else if (intReset) begin
      periodicFlag <= 1'b0;
    end else if (link.periodicTick) begin
      periodicFlag <= 1'b1;
    end else if (wrStatus && wrData[`CTW_BIT_PER_CLR]) begin
      periodicFlag <= 1'b0;
    end
  end

  always_comb begin
    statusValue = 8'h00;
    statusValue[`CTW_BIT_OVF_FLAG] = overflowFlag;
    statusValue[`CTW_BIT_PER_FLAG] = periodicFlag;
    statusValue[`CTW_BIT_OVF_IE]   = overflowIrqEnable;
    statusValue[`CTW_BIT_PER_IE]   = periodicIrqEnable;
    statusValue[`CTW_BIT_RATE_HI]  = rateSelect[1];
    statusValue[`CTW_BIT_RATE_LO]  = rateSelect[0];
  end

  // ***********************************************************************
  // Read port
  // ***********************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData <= `CTW_RDATA_RESET;
    end else if (rdStatus) begin
      rdData <= statusValue;
    end else if (rdCount) begin
      rdData <= countValue;
    end else if (rdEn) begin
      rdData <= `CTW_RDATA_RESET;
    end
  end

  // ***********************************************************************
  // Interrupt, wake and reset outputs
  // ***********************************************************************
  assign next_irqReq = (overflowFlag && overflowIrqEnable) ||
                       (periodicFlag && periodicIrqEnable);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irqReq      <= 1'b0;
      wakeReq     <= 1'b0;
      cpuResetReq <= 1'b0;
      porBusy     <= 1'b1;
    end else begin
      irqReq      <= next_irqReq;
      wakeReq     <= next_irqReq && waitMode;
      cpuResetReq <= link.wdogExpire;
      porBusy     <= link.porActive;
    end
  end

  // ***********************************************************************
  // Checks
  // ***********************************************************************
  property p_count_step;
    @(posedge clk) disable iff (!reset_n)
    preTick && !link.chainClear |=> countValue == $past(countValue) + 8'h01;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("count did not step after four clocks");

  property p_count_hold;
    @(posedge clk) disable iff (!reset_n)
    !preTick && !link.chainClear |=> countValue == $past(countValue);
  endproperty
  a_count_hold: assert property (p_count_hold)
    else $error("count moved between prescaler ticks");

  property p_ovf_set;
    @(posedge clk) disable iff (!reset_n)
    ovfEvent && !intReset |=> overflowFlag && countValue == 8'h00;
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("overflow flag missed at wrap");

  property p_irq;
    @(posedge clk) disable iff (!reset_n)
    (overflowFlag && overflowIrqEnable) || (periodicFlag && periodicIrqEnable)
      |=> irqReq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled flag gave no interrupt request");

  property p_per_set;
    @(posedge clk) disable iff (!reset_n)
    link.periodicTick && !intReset |=> periodicFlag;
  endproperty
  a_per_set: assert property (p_per_set)
    else $error("periodic flag missed at tap");

  property p_clr_bits_zero;
    @(posedge clk) disable iff (!reset_n)
    rdStatus |=> rdData[`CTW_BIT_OVF_CLR] == 1'b0 &&
                 rdData[`CTW_BIT_PER_CLR] == 1'b0;
  endproperty
  a_clr_bits_zero: assert property (p_clr_bits_zero)
    else $error("clear bits did not read as zero");

  property p_reset_state;
    @(posedge clk) disable iff (!reset_n)
    intReset |=> rateSelect == `CTW_RATE_RESET && !overflowFlag &&
                 !periodicFlag && !overflowIrqEnable && !periodicIrqEnable;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("reset left control state dirty");

  property p_count_read;
    @(posedge clk) disable iff (!reset_n)
    rdCount |=> rdData == $past(countValue);
  endproperty
  a_count_read: assert property (p_count_read)
    else $error("count read returned wrong value");

  property p_ext_clear;
    @(posedge clk) disable iff (!reset_n)
    !extReset_n |=> chainCount == `CTW_CHAIN_ZERO;
  endproperty
  a_ext_clear: assert property (p_ext_clear)
    else $error("external reset left chain running");

  property p_tick_period;
    @(posedge clk) disable iff (!reset_n)
    link.periodicTick |-> ovfEvent && countValue == 8'hFF;
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("periodic tick off the selected tap");

  property p_irq_quiet;
    @(posedge clk) disable iff (!reset_n)
    !(overflowFlag && overflowIrqEnable) &&
      !(periodicFlag && periodicIrqEnable) |=> !irqReq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("interrupt request without an enabled flag");

  property p_wake;
    @(posedge clk) disable iff (!reset_n)
    wakeReq |-> irqReq && $past(waitMode);
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake request outside wait mode");

  property p_ovf_clear;
    @(posedge clk) disable iff (!reset_n)
    wrStatus && wrData[`CTW_BIT_OVF_CLR] && !ovfEvent |=> !overflowFlag;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear)
    else $error("overflow clear bit did not clear flag");

  property p_per_clear;
    @(posedge clk) disable iff (!reset_n)
    wrStatus && wrData[`CTW_BIT_PER_CLR] && !link.periodicTick
      |=> !periodicFlag;
  endproperty
  a_per_clear: assert property (p_per_clear)
    else $error("periodic clear bit did not clear flag");

  property p_ovf_hold;
    @(posedge clk) disable iff (!reset_n)
    overflowFlag && !intReset && !(wrStatus && wrData[`CTW_BIT_OVF_CLR])
      |=> overflowFlag;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold)
    else $error("overflow flag dropped without a clear");

  property p_rate_write;
    @(posedge clk) disable iff (!reset_n)
    wrStatus && !intReset |=>
      rateSelect[1] == $past(wrData[`CTW_BIT_RATE_HI]) &&
      rateSelect[0] == $past(wrData[`CTW_BIT_RATE_LO]);
  endproperty
  a_rate_write: assert property (p_rate_write)
    else $error("rate select write not taken");

  property p_unmapped_read;
    @(posedge clk) disable iff (!reset_n)
    rdEn && !rdStatus && !rdCount |=> rdData == `CTW_RDATA_RESET;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read returned nonzero data");

endmodule

`default_nettype wire

// [tb/ctw_core_timer_bench.sv]
// Holds the self-checking testbench of the core timer top.
// Assumes the design files under hw/ and the timer constants header.
`timescale 1ns/10ps
`default_nettype none
`include "ctw_params.svh"

module ctw_core_timer_bench;

  // ***********************************************************************
  // Signals and instance
  // ***********************************************************************
  localparam int PorCyc = 16;

  logic                   clk;
  logic                   reset_n;
  logic                   extReset_n;
  logic                   waitMode;
  logic [`CTW_ADDR_W-1:0] addr;
  logic                   wrEn;
  logic                   rdEn;
  logic [7:0]             wrData;
  logic [7:0]             rdData;
  logic                   irqReq;
  logic                   wakeReq;
  logic                   cpuResetReq;
  logic                   porBusy;
  int                     err_count;
  int                     cmp_count;
  int                     cyc;
  logic [7:0]             wdSeen;

  ctw_core_timer #(
    .WdogEnable (1'b1),
    .PorCycles  (PorCyc)
  ) i_dut (
    .clk         (clk),
    .reset_n     (reset_n),
    .extReset_n  (extReset_n),
    .waitMode    (waitMode),
    .addr        (addr),
    .wrEn        (wrEn),
    .rdEn        (rdEn),
    .wrData      (wrData),
    .rdData      (rdData),
    .irqReq      (irqReq),
    .wakeReq     (wakeReq),
    .cpuResetReq (cpuResetReq),
    .porBusy     (porBusy)
  );

  always #5 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (reset_n === 1'b1 && cpuResetReq !== 1'b0) begin
      wdSeen <= 8'h01;
    end
  end

  // ***********************************************************************
  // Shared tasks
  // ***********************************************************************
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkn(input string what, input int lo, input int hi,
                      input int got);
    cmp_count++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    addr   = a;
    wrData = d;
    wrEn   = 1'b1;
    tick(1);
    wrEn = 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [13:0] a, output logic [7:0] d);
    addr = a;
    rdEn = 1'b1;
    tick(1);
    rdEn = 1'b0;
    tick(1);
    d = rdData;
  endtask

  task automatic wait_irq(input int lim, output int at);
    int n;
    n = 0;
    while (irqReq !== 1'b1) begin
      tick(1);
      n++;
      if (n > lim) begin
        err_count++;
        $display("[FAIL] irqReq expected 1 seen %b", irqReq);
        test_done();
      end
    end
    at = cyc;
  endtask

  task automatic ext_reset;
    extReset_n = 1'b0;
    tick(3);
    extReset_n = 1'b1;
  endtask

  // ***********************************************************************
  // Scenarios
  // ***********************************************************************
  task automatic t_power_on;
    int n;
    logic [7:0] d;
    n = 0;
    while (porBusy !== 1'b0) begin
      tick(1);
      n++;
      if (n > 100) begin
        err_count++;
        $display("[FAIL] porBusy expected 0 seen %b", porBusy);
        test_done();
      end
    end
    chkn("power-on delay", PorCyc - 1, PorCyc + 3, n);
    rd(`CTW_OFS_STATUS, d);
    chk("status reset", 8'h03, d);
    rd(`CTW_OFS_COUNT, d);
    chk("count after power-on", 8'h00, d);
    $display("Test power_on done");
  endtask

  task automatic t_registers;
    logic [7:0] a;
    logic [7:0] b;
    for (int r = 0; r < 4; r++) begin
      wr(`CTW_OFS_STATUS, 8'(r));
      rd(`CTW_OFS_STATUS, a);
      chk("rate select", 8'(r), a & 8'h3F);
    end
    rd(`CTW_OFS_COUNT, a);
    wr(`CTW_OFS_COUNT, 8'hFF);
    tick(4);
    rd(`CTW_OFS_COUNT, b);
    chk("count step", a + 8'h02, b);
    rd(`CTW_OFS_WDOG, a);
    chk("watchdog address read", 8'h00, a);
    rd(14'h0100, a);
    chk("unmapped read", 8'h00, a);
    $display("Test registers done");
  endtask

  task automatic t_overflow;
    int t1;
    int t2;
    logic [7:0] d;
    wr(`CTW_OFS_STATUS, 8'h0F);
    chk("irq with enables off", 8'h00, {7'h00, irqReq});
    wr(`CTW_OFS_STATUS, 8'h23);
    wait_irq(1100, t1);
    rd(`CTW_OFS_STATUS, d);
    chk("overflow flag", 8'h80, d & 8'h8C);
    waitMode = 1'b1;
    tick(2);
    chk("wake in wait", 8'h01, {7'h00, wakeReq});
    waitMode = 1'b0;
    wr(`CTW_OFS_STATUS, 8'h23);
    tick(1);
    chk("clear bit zero", 8'h01, {7'h00, irqReq});
    wr(`CTW_OFS_STATUS, 8'h2B);
    tick(1);
    chk("clear bit one", 8'h00, {7'h00, irqReq});
    wait_irq(1100, t2);
    chkn("overflow period", 1024, 1024, t2 - t1);
    wr(`CTW_OFS_STATUS, 8'h0B);
    $display("Test overflow done");
  endtask

  task automatic t_periodic;
    int t0;
    int t1;
    int t2;
    logic [7:0] d;
    wr(`CTW_OFS_STATUS, 8'h30);
    ext_reset();
    t0 = cyc;
    rd(`CTW_OFS_STATUS, d);
    chk("status after ext reset", 8'h03, d);
    rd(`CTW_OFS_COUNT, d);
    chk("count after ext reset", 8'h00, d);
    wr(`CTW_OFS_STATUS, 8'h10);
    wr(`CTW_OFS_WDOG, 8'h00);
    wait_irq(16500, t1);
    chkn("first periodic", 16380, 16390, t1 - t0);
    rd(`CTW_OFS_STATUS, d);
    chk("periodic flag", 8'hC0, d & 8'hCC);
    wr(`CTW_OFS_STATUS, 8'h14);
    tick(1);
    chk("periodic clear", 8'h00, {7'h00, irqReq});
    wr(`CTW_OFS_WDOG, 8'h00);
    wait_irq(16500, t2);
    chkn("periodic period", 16384, 16384, t2 - t1);
    ext_reset();
    t0 = cyc;
    wr(`CTW_OFS_WDOG, 8'h00);
    wr(`CTW_OFS_STATUS, 8'h11);
    wait_irq(33000, t1);
    chkn("slower periodic", 32764, 32774, t1 - t0);
    chk("no watchdog reset", 8'h00, wdSeen);
    $display("Test periodic done");
  endtask

  // ***********************************************************************
  // Main sequence
  // ***********************************************************************
  initial begin
    clk        = 1'b0;
    reset_n    = 1'b0;
    extReset_n = 1'b1;
    waitMode   = 1'b0;
    addr       = 14'h0000;
    wrEn       = 1'b0;
    rdEn       = 1'b0;
    wrData     = 8'h00;
    err_count  = 0;
    cmp_count  = 0;
    cyc        = 0;
    wdSeen     = 8'h00;
    tick(3);
    reset_n = 1'b1;
    t_power_on();
    t_registers();
    t_overflow();
    t_periodic();
    test_done();
  end

endmodule

`default_nettype wire
